/* msm_defs.vh */
// Constants shared by the motion safety monitor.
// Functional notes
// - A hardware limit is clear only while its input is driven low.
// - Each motor reads the limit pair selected by its limit_flag_config.
// - On a limit hit, stop the motor's trajectory at its limit_decel_rate.
// - If its coordinate system runs a program, stop all its motors, like abort.
// - Minus input blocks positive moves, plus input blocks negative moves.
// - Bit 17 of limit_flag_config set disables hardware limits; default enabled.
// - Positive and negative soft limits act like hardware limits.
// - A soft limit value of zero disables that limit.
// - Soft limits are off while homing until trigger, then referenced to new home.
// - Following error is commanded minus actual, checked against fatal and warning.
// - Fatal error kills: zero output, amplifier off, moves and programs aborted.
// - limit_flag_config picks kill spread: motor, coordinate system, or all.
// - After a kill, only a motor, system, or card re-enable command restores.
// - Warning limit exceeded sets motor and coordinate system warning bits.
// - A zero fatal or warning limit disables that check.
// - Integrated check runs only with negative integrator_bound; magnitude bounds it.
// - Integrator clamps to the bound; sitting at clamp kills like fatal error.
// - Integrator stops growing while the command output is saturated.
// - Integrated kill sets fault and integrated-fault bits; re-enable clears both.
`ifndef MSM_DEFS_VH
`define MSM_DEFS_VH
`define MSM_NM 4
`define MSM_NCS 2
`define MSM_AW 8
`define MSM_NREG 32
`define MSM_IDX_FLAGCFG 3'h0
`define MSM_IDX_DECEL 3'h1
`define MSM_IDX_POSLIM 3'h2
`define MSM_IDX_NEGLIM 3'h3
`define MSM_IDX_FATAL 3'h4
`define MSM_IDX_WARN 3'h5
`define MSM_IDX_IBOUND 3'h6
`define MSM_IDX_STATUS 3'h7
`define MSM_ADDR_CMD 8'h80
`define MSM_ADDR_CSMAP 8'h84
`define MSM_ADDR_GSTAT 8'h88
`define MSM_CFG_SEL_HI 1
`define MSM_CFG_SEL_LO 0
`define MSM_CFG_HWDIS 17
`define MSM_CFG_SPR_HI 22
`define MSM_CFG_SPR_LO 21
`define MSM_SPREAD_CS 2'h1
`define MSM_SPREAD_ALL_BIT 1
`define MSM_CMD_MOT_LO 0
`define MSM_CMD_CS_LO 4
`define MSM_CMD_CARD 8
`define MSM_ST_PLIM 0
`define MSM_ST_MLIM 1
`define MSM_ST_SPOS 2
`define MSM_ST_SNEG 3
`define MSM_ST_WARN 4
`define MSM_ST_FEFLT 5
`define MSM_ST_INTFLT 6
`define MSM_ST_KILLED 7
`define MSM_ST_STOP 8
`define MSM_RESP_OKAY 2'h0
`define MSM_RESP_SLVERR 2'h2
`define MSM_ZERO32 32'h0000_0000
`define MSM_LIM_RST 4'hf
`endif

/* msm_monitor.v */
// Per-motor limit and following error supervisor with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "msm_defs.vh"
module msm_monitor (
  input  wire                      aclk,
  input  wire                      aresetn,
  input  wire                      ce,
  input  wire [`MSM_AW-1:0]        s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output wire                      s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output wire                      s_axi_wready,
  output wire [1:0]                s_axi_bresp,
  output wire                      s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [`MSM_AW-1:0]        s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output wire                      s_axi_arready,
  output wire [31:0]               s_axi_rdata,
  output wire [1:0]                s_axi_rresp,
  output wire                      s_axi_rvalid,
  input  wire                      s_axi_rready,
  input  wire [`MSM_NM-1:0]        plus_travel_input,
  input  wire [`MSM_NM-1:0]        minus_travel_input,
  input  wire                      servo_tick,
  input  wire [`MSM_NM*32-1:0]     cmd_pos,
  input  wire [`MSM_NM*32-1:0]     act_pos,
  input  wire [`MSM_NM-1:0]        move_positive,
  input  wire [`MSM_NM-1:0]        moving,
  input  wire [`MSM_NM-1:0]        output_saturated,
  input  wire [`MSM_NM-1:0]        homing_active,
  input  wire [`MSM_NM-1:0]        home_trigger,
  input  wire [`MSM_NCS-1:0]       cs_running,
  output wire [`MSM_NM-1:0]        amp_enable,
  output wire [`MSM_NM-1:0]        zero_output,
  output wire [`MSM_NM-1:0]        stop_request,
  output wire [`MSM_NM*32-1:0]     stop_decel_rate,
  output wire [`MSM_NM*32-1:0]     integrator_value,
  output wire [`MSM_NM-1:0]        warning_motor,
  output wire [`MSM_NCS-1:0]       warning_cs,
  output wire [`MSM_NCS-1:0]       cs_abort
);

  reg  [31:0]              regs_q [0:`MSM_NREG-1];
  reg  [`MSM_NM-1:0]       csmap_q;
  reg  [`MSM_NM-1:0]       plus_s1_q;
  reg  [`MSM_NM-1:0]       plus_s2_q;
  reg  [`MSM_NM-1:0]       minus_s1_q;
  reg  [`MSM_NM-1:0]       minus_s2_q;
  reg                      aw_hold_q;
  reg                      w_hold_q;
  reg  [`MSM_AW-1:0]       awaddr_q;
  reg  [31:0]              wdata_q;
  reg  [3:0]               wstrb_q;
  reg                      bvalid_q;
  reg  [1:0]               bresp_q;
  reg                      rvalid_q;
  reg  [31:0]              rdata_q;
  reg  [1:0]               rresp_q;
  reg  [`MSM_NCS-1:0]      cs_abort_q;
  reg  [31:0]              rd_data;
  reg  [1:0]               rd_resp;
  reg  [1:0]               wr_resp;
  reg  [`MSM_NM-1:0]       kill_in;
  reg  [`MSM_NCS-1:0]      cs_lim;
  reg  [`MSM_NCS-1:0]      cs_fatal;
  reg  [`MSM_NCS-1:0]      cs_warn;
  wire [`MSM_NM-1:0]       offend;
  wire [`MSM_NM-1:0]       lim_stop;
  wire [`MSM_NM-1:0]       warn_v;
  wire [`MSM_NM-1:0]       killed_v;
  wire [`MSM_NM*2-1:0]     spread_v;
  wire [`MSM_NM*32-1:0]    stat_bus;
  wire                     tick;
  wire                     do_wr;
  wire                     wr_motor;
  wire                     cmd_wr;
  wire [4:0]               wr_idx;
  integer                  i;
  integer                  b;
  integer                  k;
  integer                  m;

  assign tick          = ce & servo_tick;
  // Handshakes are held off while frozen, so no transfer is taken that the state cannot record.
  assign s_axi_awready = ce & ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid  = ce & bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_rvalid  = ce & rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign cs_abort      = cs_abort_q;
  assign warning_cs    = cs_warn;
  assign do_wr         = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_motor      = ~awaddr_q[7];
  assign wr_idx        = awaddr_q[6:2];
  assign cmd_wr        = do_wr & (awaddr_q == `MSM_ADDR_CMD);

  // Motor registers sit in words 0..31; words at offset 0x80 and up are global.
  always @* begin
    wr_resp = `MSM_RESP_OKAY;
    if (!wr_motor && awaddr_q != `MSM_ADDR_CMD && awaddr_q != `MSM_ADDR_CSMAP &&
        awaddr_q != `MSM_ADDR_GSTAT) begin
      wr_resp = `MSM_RESP_SLVERR;
    end
  end

  always @* begin
    rd_data = `MSM_ZERO32;
    rd_resp = `MSM_RESP_OKAY;
    if (!s_axi_araddr[7]) begin
      if (s_axi_araddr[4:2] == `MSM_IDX_STATUS) begin
        rd_data = stat_bus[s_axi_araddr[6:5]*32 +: 32];
      end else begin
        rd_data = regs_q[s_axi_araddr[6:2]];
      end
    end else if (s_axi_araddr == `MSM_ADDR_CSMAP) begin
      rd_data[`MSM_NM-1:0] = csmap_q;
    end else if (s_axi_araddr == `MSM_ADDR_GSTAT) begin
      rd_data[`MSM_NM-1:0] = killed_v;
      rd_data[`MSM_NM+`MSM_NCS-1:`MSM_NM] = cs_warn;
    end else if (s_axi_araddr != `MSM_ADDR_CMD) begin
      rd_resp = `MSM_RESP_SLVERR;
    end
  end

  // Fault spreading and coordinate system stops are gathered across all motors.
  always @* begin
    kill_in  = {`MSM_NM{1'b0}};
    cs_lim   = {`MSM_NCS{1'b0}};
    cs_fatal = {`MSM_NCS{1'b0}};
    cs_warn  = {`MSM_NCS{1'b0}};
    for (m = 0; m < `MSM_NM; m = m + 1) begin
      for (k = 0; k < `MSM_NM; k = k + 1) begin
        if (offend[k] && (k == m || spread_v[k*2+`MSM_SPREAD_ALL_BIT] ||
            (spread_v[k*2 +: 2] == `MSM_SPREAD_CS && csmap_q[k] == csmap_q[m]))) begin
          kill_in[m] = 1'b1;
        end
      end
    end
    for (m = 0; m < `MSM_NCS; m = m + 1) begin
      for (k = 0; k < `MSM_NM; k = k + 1) begin
        if (csmap_q[k] == m[0]) begin
          cs_lim[m]   = cs_lim[m] | (lim_stop[k] & cs_running[m]);
          cs_fatal[m] = cs_fatal[m] | offend[k];
          cs_warn[m]  = cs_warn[m] | warn_v[k];
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < `MSM_NREG; i = i + 1) begin
        regs_q[i] <= (i[2:0] == `MSM_IDX_FLAGCFG) ? {30'h0000_0000, i[4:3]} : `MSM_ZERO32;
      end
      csmap_q    <= {`MSM_NM{1'b0}};
      plus_s1_q  <= `MSM_LIM_RST;
      plus_s2_q  <= `MSM_LIM_RST;
      minus_s1_q <= `MSM_LIM_RST;
      minus_s2_q <= `MSM_LIM_RST;
      aw_hold_q  <= 1'b0;
      w_hold_q   <= 1'b0;
      awaddr_q   <= {`MSM_AW{1'b0}};
      wdata_q    <= `MSM_ZERO32;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `MSM_RESP_OKAY;
      rvalid_q   <= 1'b0;
      rdata_q    <= `MSM_ZERO32;
      rresp_q    <= `MSM_RESP_OKAY;
      cs_abort_q <= {`MSM_NCS{1'b0}};
    end else if (ce) begin
      // Open inputs float high, so the reset value already counts as in the limit.
      plus_s1_q  <= plus_travel_input;
      plus_s2_q  <= plus_s1_q;
      minus_s1_q <= minus_travel_input;
      minus_s2_q <= minus_s1_q;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_resp;
        if (wr_motor && wr_idx[2:0] != `MSM_IDX_STATUS) begin
          for (b = 0; b < 4; b = b + 1) begin
            if (wstrb_q[b]) begin
              regs_q[wr_idx][b*8 +: 8] <= wdata_q[b*8 +: 8];
            end
          end
        end
        if (awaddr_q == `MSM_ADDR_CSMAP && wstrb_q[0]) begin
          csmap_q <= wdata_q[`MSM_NM-1:0];
        end
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_data;
        rresp_q  <= rd_resp;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      cs_abort_q <= tick ? (cs_lim | cs_fatal) : {`MSM_NCS{1'b0}};
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MSM_NM; g = g + 1) begin : g_mot
      reg                killed_q;
      reg                fe_flt_q;
      reg                int_flt_q;
      reg                warn_q;
      reg                stop_q;
      reg                found_q;
      reg  signed [31:0] home_q;
      reg  signed [31:0] integ_q;
      wire [31:0]        cfg    = regs_q[g*8+`MSM_IDX_FLAGCFG];
      wire signed [31:0] poslim = regs_q[g*8+`MSM_IDX_POSLIM];
      wire signed [31:0] neglim = regs_q[g*8+`MSM_IDX_NEGLIM];
      wire [31:0]        fatal  = regs_q[g*8+`MSM_IDX_FATAL];
      wire [31:0]        warn   = regs_q[g*8+`MSM_IDX_WARN];
      wire signed [31:0] bound  = regs_q[g*8+`MSM_IDX_IBOUND];
      wire [1:0]         sel    = cfg[`MSM_CFG_SEL_HI:`MSM_CFG_SEL_LO];
      wire               hw_on  = ~cfg[`MSM_CFG_HWDIS];
      // A high level means not held low, which is treated as in the limit.
      wire               plim   = hw_on & plus_s2_q[sel];
      wire               mlim   = hw_on & minus_s2_q[sel];
      wire signed [31:0] cmdp   = cmd_pos[g*32 +: 32];
      wire signed [31:0] actp   = act_pos[g*32 +: 32];
      wire signed [31:0] ferr   = cmdp - actp;
      wire [31:0]        fmag   = ferr[31] ? (32'h0000_0000 - ferr) : ferr;
      wire signed [31:0] rel    = actp - home_q;
      wire               soft_on = ~(homing_active[g] & ~found_q);
      wire               spos   = soft_on & (poslim != 0) & (rel >= poslim);
      wire               sneg   = soft_on & (neglim != 0) & (rel <= neglim);
      wire               fat_hit = (fatal != 0) & (fmag > fatal);
      wire               wrn_hit = (warn != 0) & (fmag > warn);
      wire               int_on = bound[31];
      wire [31:0]        bmag   = int_on ? (32'h0000_0000 - bound) : bound;
      wire signed [32:0] bm33   = {1'b0, bmag};
      wire signed [32:0] nbm33  = 33'h0_0000_0000 - bm33;
      wire signed [32:0] sum    = {integ_q[31], integ_q} + {ferr[31], ferr};
      wire [32:0]        smag   = sum[32] ? (33'h0_0000_0000 - sum) : sum;
      wire [31:0]        imag   = integ_q[31] ? (32'h0000_0000 - integ_q) : integ_q;
      wire               hold   = output_saturated[g] & (smag > {1'b0, imag});
      wire signed [32:0] sat    = (sum > bm33) ? bm33 : ((sum < nbm33) ? nbm33 : sum);
      wire               at_clamp = int_on & (bmag != 0) &
                                    ({integ_q[31], integ_q} == bm33 ||
                                     {integ_q[31], integ_q} == nbm33);
      // The plus input only stops negative moves so the axis can back out.
      wire               stp = moving[g] & (move_positive[g] ? (mlim | spos) :
                                                             (plus_s2_q[sel] & hw_on | sneg));
      wire               re_en = cmd_wr & (wdata_q[`MSM_CMD_MOT_LO+g] | wdata_q[`MSM_CMD_CARD] |
                                 wdata_q[`MSM_CMD_CS_LO+csmap_q[g]]);

      assign offend[g]   = fat_hit | at_clamp;
      assign lim_stop[g] = stp;
      assign warn_v[g]   = warn_q;
      assign killed_v[g] = killed_q;
      assign spread_v[g*2 +: 2] = cfg[`MSM_CFG_SPR_HI:`MSM_CFG_SPR_LO];
      assign amp_enable[g]   = ~killed_q;
      assign zero_output[g]  = killed_q;
      assign stop_request[g] = stop_q;
      assign warning_motor[g] = warn_q;
      assign stop_decel_rate[g*32 +: 32] = regs_q[g*8+`MSM_IDX_DECEL];
      assign integrator_value[g*32 +: 32] = integ_q;
      assign stat_bus[g*32 +: 32] = {23'h00_0000, stop_q, killed_q, int_flt_q, fe_flt_q,
                                     warn_q, sneg, spos, mlim, plim};

      always @(posedge aclk) begin
        if (!aresetn) begin
          killed_q  <= 1'b0;
          fe_flt_q  <= 1'b0;
          int_flt_q <= 1'b0;
          warn_q    <= 1'b0;
          stop_q    <= 1'b0;
          found_q   <= 1'b0;
          home_q    <= `MSM_ZERO32;
          integ_q   <= `MSM_ZERO32;
        end else if (ce) begin
          // Set wins over a re-enable that lands in the same cycle.
          killed_q  <= (killed_q & ~re_en) | (tick & kill_in[g]);
          fe_flt_q  <= (fe_flt_q & ~re_en) | (tick & (fat_hit | at_clamp));
          int_flt_q <= (int_flt_q & ~re_en) | (tick & at_clamp);
          if (homing_active[g] && home_trigger[g] && !found_q) begin
            found_q <= 1'b1;
            home_q  <= actp;
          end else if (!homing_active[g]) begin
            found_q <= 1'b0;
          end
          if (tick) begin
            warn_q <= wrn_hit;
            // The stop holds until the trajectory has come to rest.
            stop_q <= stp | cs_lim[csmap_q[g]] | (stop_q & moving[g]);
            if (killed_q) begin
              integ_q <= `MSM_ZERO32;
            end else if (!hold) begin
              integ_q <= sat[31:0];
            end
          end
        end
      end
    end
  endgenerate

endmodule // msm_monitor
`default_nettype wire

/* msm_monitor_asserts.sv */
// Concurrent checks on the outputs of the motion safety monitor.
`timescale 1ns/1ps
`default_nettype none
`include "msm_defs.vh"
module msm_monitor_asserts (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                ce,
  input wire logic                servo_tick,
  input wire logic                s_axi_bvalid,
  input wire logic [`MSM_NM-1:0]  amp_enable,
  input wire logic [`MSM_NM-1:0]  zero_output,
  input wire logic [`MSM_NM-1:0]  stop_request,
  input wire logic [`MSM_NM-1:0]  warning_motor,
  input wire logic [`MSM_NCS-1:0] warning_cs,
  input wire logic [`MSM_NCS-1:0] cs_abort
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_amp_kill;
    amp_enable == ~zero_output;
  endproperty
  a_amp_kill: assert property (p_amp_kill) else $error("amp enable not inverse of kill");
  property p_kill_tick;
    |(zero_output & ~$past(zero_output)) |-> $past(servo_tick && ce);
  endproperty
  a_kill_tick: assert property (p_kill_tick) else $error("kill outside a servo tick");
  property p_stop_tick;
    stop_request != $past(stop_request) |-> $past(servo_tick && ce);
  endproperty
  a_stop_tick: assert property (p_stop_tick) else $error("stop changed off tick");
  property p_warn_tick;
    $changed(warning_motor) |-> $past(servo_tick && ce);
  endproperty
  a_warn_tick: assert property (p_warn_tick) else $error("warning changed off tick");
  property p_warn_cs;
    (|warning_cs) == (|warning_motor);
  endproperty
  a_warn_cs: assert property (p_warn_cs) else $error("system warning mismatch");
  property p_abort_cause;
    |cs_abort |-> $past(servo_tick && ce) || !$past(ce);
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("abort without tick");
  property p_abort_pulse;
    ce && !servo_tick |=> cs_abort == 2'h0;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than a pulse");
  property p_freeze;
    !ce |=> $stable(zero_output) && $stable(stop_request) && $stable(warning_motor);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  // A kill clears only through a register write, so a response follows shortly.
  property p_restore;
    |(~zero_output & $past(zero_output)) |-> ##[0:2] s_axi_bvalid;
  endproperty
  a_restore: assert property (p_restore) else $error("kill cleared without command");
  c_kill_all: cover property (zero_output == 4'hf);
  c_stop: cover property (|stop_request);
  c_abort: cover property (|cs_abort);
endmodule // msm_monitor_asserts
bind msm_monitor msm_monitor_asserts msm_monitor_asserts_inst (.aclk, .aresetn, .ce,
  .servo_tick, .s_axi_bvalid, .amp_enable, .zero_output, .stop_request, .warning_motor,
  .warning_cs, .cs_abort);
`default_nettype wire

/* msm_switch_model.sv */
// Limit switch side model for the motion safety monitor.
`timescale 1ns/1ps
`default_nettype none
module msm_switch_model (
  input  wire logic [3:0] closed_p,
  input  wire logic [3:0] closed_m,
  output wire logic [3:0] plus_travel_input,
  output wire logic [3:0] minus_travel_input
);
  // A closed switch sinks the input low; an open or broken one floats to the in-limit level.
  assign plus_travel_input  = ~closed_p;
  assign minus_travel_input = ~closed_m;
endmodule // msm_switch_model
`default_nettype wire

/* motion_safety_monitor_bench.sv */
// Self-checking bench for the motion safety monitor.
`timescale 1ns/1ps
`default_nettype none
`include "msm_defs.vh"
module motion_safety_monitor_bench;
  typedef struct packed {logic [31:0] fe; logic pc, mc, mp, mv, es, ew;} msm_row_t;
  logic         aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, servo_tick = 1'h0;
  logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]  s_axi_wdata = 32'h0, act0 = 32'h0, cmd0 = 32'h0, rdv = 32'h0;
  logic [3:0]   s_axi_wstrb = 4'hf, move_positive = 4'h0, moving = 4'h0, clp = 4'hf;
  logic [3:0]   output_saturated = 4'h0, homing_active = 4'h0, home_trigger = 4'h0, clm = 4'hf;
  logic [1:0]   cs_running = 2'h0, rr = 2'h0, br = 2'h0;
  wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]   s_axi_bresp, s_axi_rresp, warning_cs, cs_abort;
  wire  [31:0]  s_axi_rdata;
  wire  [3:0]   plus_travel_input, minus_travel_input, amp_enable, zero_output;
  wire  [3:0]   stop_request, warning_motor;
  wire  [127:0] cmd_pos = {96'h0, cmd0};
  wire  [127:0] act_pos = {96'h0, act0};
  wire  [127:0] stop_decel_rate, integrator_value;
  integer       num_errors = 0, num_checks = 0, i;
  msm_row_t     rows [0:8];
  logic [31:0]  scfg [0:2] = '{32'h0, 32'h20_0000, 32'h40_0000};
  logic [31:0]  scmd [0:2] = '{32'h1, 32'h10, 32'h100};
  logic [3:0]   skill [0:2] = '{4'h1, 4'hd, 4'hf};
  msm_monitor msm_monitor_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .plus_travel_input, .minus_travel_input,
    .servo_tick, .cmd_pos, .act_pos, .move_positive, .moving, .output_saturated,
    .homing_active, .home_trigger, .cs_running, .amp_enable, .zero_output, .stop_request,
    .stop_decel_rate, .integrator_value, .warning_motor, .warning_cs, .cs_abort);
  msm_switch_model msm_switch_model_inst (.closed_p(clp), .closed_m(clm), .plus_travel_input,
    .minus_travel_input);
  always #25 aclk = ~aclk;
  task end_sim;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (!ta && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (!tw && s_axi_wready) s_axi_wvalid <= 1'h0;
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
    end while (!(ta && tw));
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    rdv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  // Three idle cycles let the limit synchronisers settle before the tick samples them.
  task run(input logic [31:0] a, input logic [31:0] fe, input logic p, input logic m);
    @(posedge aclk);
    act0 <= a;
    cmd0 <= a + fe;
    move_positive[0] <= p;
    moving[0] <= m;
    repeat (3) @(posedge aclk);
    servo_tick <= 1'h1;
    @(posedge aclk);
    servo_tick <= 1'h0;
    @(negedge aclk);
  endtask
  initial begin
    #200_000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    rows = '{{32'ha, 6'h3c}, {32'h32, 6'h3c}, {32'h64, 6'h3d}, {32'hffff_ffc4, 6'h3d},
             {32'h0, 6'h2e}, {32'h0, 6'h28}, {32'h0, 6'h1c}, {32'h0, 6'h16}, {32'h0, 6'h30}};
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    cmp(32'(amp_enable), 32'hf, "reset amp");
    cmp(32'({zero_output, stop_request, warning_motor}), 32'h0, "reset out");
    wr(8'h10, 32'h64);
    wr(8'h14, 32'h32);
    wr(8'h04, 32'h7);
    for (i = 0; i < 9; i = i + 1) begin
      @(posedge aclk);
      clp[0] <= rows[i].pc;
      clm[0] <= rows[i].mc;
      run(32'h0, rows[i].fe, rows[i].mp, rows[i].mv);
      cmp(32'(stop_request[0]), 32'(rows[i].es), "stop");
      cmp(32'(warning_motor[0]), 32'(rows[i].ew), "warn");
      cmp(32'(warning_cs), 32'(rows[i].ew), "cs warn");
      cmp(32'(zero_output[0]), 32'h0, "kill");
    end
    wr(8'h84, 32'h2);
    for (i = 0; i < 3; i = i + 1) begin
      wr(8'h00, scfg[i]);
      run(32'h0, 32'h96, 1'h0, 1'h0);
      cmp(32'(zero_output), 32'(skill[i]), "spread");
      cmp(32'(amp_enable), {28'h0, ~skill[i]}, "amp");
      if (i == 0) cmp(32'(cs_abort), 32'h1, "fatal abort");
      run(32'h0, 32'h0, 1'h0, 1'h0);
      cmp(32'(zero_output), 32'(skill[i]), "held");
      wr(8'h80, scmd[i]);
      cmp(32'(zero_output), 32'h0, "restore");
    end
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    run(32'h0, 32'h4000_0000, 1'h0, 1'h0);
    cmp(32'({zero_output[0], warning_motor[0]}), 32'h0, "checks off");
    wr(8'h10, 32'h64);
    wr(8'h14, 32'h32);
    wr(8'h00, 32'h2_0000);
    clm <= 4'he;
    run(32'h0, 32'h0, 1'h1, 1'h1);
    cmp(32'(stop_request[0]), 32'h0, "hw off");
    wr(8'h00, 32'h1);
    clm <= 4'hd;
    cs_running <= 2'h1;
    run(32'h0, 32'h0, 1'h1, 1'h1);
    cmp(32'(stop_request[0]), 32'h1, "pair");
    cmp(32'(cs_abort), 32'h1, "cs stop");
    cmp(stop_decel_rate[31:0], 32'h7, "decel");
    @(posedge aclk);
    clm <= 4'hf;
    cs_running <= 2'h0;
    run(32'h0, 32'h0, 1'h1, 1'h0);
    wr(8'h08, 32'h3e8);
    run(32'h3e8, 32'h0, 1'h1, 1'h1);
    cmp(32'(stop_request[0]), 32'h1, "soft");
    run(32'h0, 32'h0, 1'h1, 1'h0);
    @(posedge aclk);
    homing_active <= 4'h1;
    run(32'h7d0, 32'h0, 1'h1, 1'h1);
    cmp(32'(stop_request[0]), 32'h0, "homing");
    @(posedge aclk);
    home_trigger <= 4'h1;
    @(posedge aclk);
    home_trigger <= 4'h0;
    homing_active <= 4'h0;
    run(32'hb54, 32'h0, 1'h1, 1'h1);
    cmp(32'(stop_request[0]), 32'h0, "new home");
    run(32'hbb8, 32'h0, 1'h1, 1'h1);
    cmp(32'(stop_request[0]), 32'h1, "new home hit");
    wr(8'h08, 32'h0);
    run(32'hbb8, 32'h0, 1'h1, 1'h0);
    run(32'hbb8, 32'h0, 1'h1, 1'h1);
    cmp(32'(stop_request[0]), 32'h0, "soft off");
    // A small bound keeps the clamp reachable with the raw error sum.
    wr(8'h18, 32'h14);
    output_saturated <= 4'h1;
    run(32'h0, 32'hf, 1'h0, 1'h0);
    cmp(integrator_value[31:0], 32'h0, "saturated");
    @(posedge aclk);
    output_saturated <= 4'h0;
    run(32'h0, 32'hf, 1'h0, 1'h0);
    run(32'h0, 32'hf, 1'h0, 1'h0);
    cmp(integrator_value[31:0], 32'h14, "clamp");
    run(32'h0, 32'hf, 1'h0, 1'h0);
    cmp(32'(zero_output[0]), 32'h0, "positive bound");
    wr(8'h18, 32'hffff_ffec);
    run(32'h0, 32'hf, 1'h0, 1'h0);
    cmp(32'(zero_output[0]), 32'h1, "integrated kill");
    rd(8'h1c);
    cmp(rdv & 32'he0, 32'he0, "fault bits");
    run(32'h0, 32'h0, 1'h0, 1'h0);
    wr(8'h80, 32'h1);
    rd(8'h1c);
    cmp(rdv & 32'he0, 32'h0, "bits cleared");
    rd(8'h8c);
    cmp({30'h0, rr}, 32'h2, "unmapped resp");
    cmp(rdv, 32'h0, "unmapped data");
    wr(8'h8c, 32'h0);
    cmp({30'h0, br}, 32'h2, "unmapped write resp");
    // A fatal error with servo ticks only while frozen must not kill; it does at the first tick once running again.
    ce <= 1'h0;
    cmd0 <= 32'h96;
    servo_tick <= 1'h1;
    repeat (3) @(posedge aclk);
    ce <= 1'h1;
    servo_tick <= 1'h0;
    @(negedge aclk);
    cmp(32'(zero_output[0]), 32'h0, "frozen");
    run(32'h0, 32'h96, 1'h0, 1'h0);
    cmp(32'(zero_output[0]), 32'h1, "thawed");
    end_sim;
  end
endmodule // motion_safety_monitor_bench
`default_nettype wire
